/* core/ucm_top.sv */
// Mode-control slice of a serial port: half-duplex receiver locking,
// smart card clock, guard time, NACK and retry, multidrop addressing and
// automatic line direction. Assumes the core framing logic supplies
// character strobes and a bit-time tick, all synchronous to hclk.
`timescale 1ns/10ps

// Shift-register FIFO: head word always sits in a flip-flop
module ucm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // Entry 0 is the head
    logic [CW-1:0] count_r;         // Words held
    logic [CW-1:0] count_nxt;
    logic [CW-1:0] wr_idx;          // Slot taken by a push
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign wr_idx = pop ? count_r - CW'(1) : count_r;
    assign out_data = mem[0];

    // Next fill level
    always_comb begin
        count_nxt = count_r;
        if (flush) begin
            count_nxt = '0;
        end else begin
            count_nxt = count_r + CW'(push) - CW'(pop);
        end
    end

    // Storage: shift on pop, write at the tail on push
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && wr_idx == CW'(i)) begin
                mem[i] <= in_data;
            end else if (pop && i < DEPTH - 1) begin
                mem[i] <= mem[i + 1];
            end
        end
    end

    // Level and handshake flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            out_valid <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            count_r <= count_nxt;
            out_valid <= count_nxt != '0;
            in_ready <= count_nxt != FULL;
        end
    end
endmodule

// Behaviour
// [R1] Reset state is full duplex, independent directions
// [R2] Half duplex locks receiver after current character
// [R3] Software keeps half-duplex setting during traffic
// [R4] Software leaves half duplex off in card mode
// [R5] Half-duplex register: enable at bit 0 only
// [R6] Card clock toggles every divider+1 cycles
// [R7] T=0 guard is two plus extra bits; extra code 0xff gives one bit
// [R8] T=0 retries NACKs, then error and lock
// [R9] Card clock enable drives and routes clock pin
// [R10] Protocol bit picks T=0 or T=1
// [R11] T=0 faulty character sends NACK unless disabled
// [R12] Polarity bit sets direction output levels
// [R13] Auto direction routes RTS pin as direction
// [R14] Auto address detect enable bit
// [R15] Receiver enable gates data in multidrop only; ignored while auto address detect is on
// [R16] Multidrop parity error byte is an address
// [R17] Address match register holds station address
// [R18] Direction held for programmed bit times after stop
// [R19] Auto detect accepts bytes after matching address
module ucm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic bit_tick,          // One pulse per bit time
    input wire logic tx_busy,           // Transmitter has data or is shifting
    input wire logic tx_char_ok,        // Character sent and accepted
    input wire logic card_nack,         // Card signalled NACK on last character
    input wire logic rx_busy,           // Character reception under way
    input wire logic rx_char_valid,     // Received character strobe
    input wire logic [7:0] rx_char,
    input wire logic rx_parity_err,     // Parity error on this character
    input wire logic rx_char_faulty,    // Card character received with error
    input wire logic rx_out_ready,      // Sink takes the head word
    output logic rx_out_valid,
    output logic [7:0] rx_out_data,
    output logic rx_space,              // Buffer can take a character
    output logic rx_lock,
    output logic tx_lock,
    output logic tx_resend,
    output logic tx_error_flag,
    output logic nack_send,
    output logic address_event,
    output logic [8:0] guard_bits,
    output logic card_clk,
    output logic card_clk_route,
    output logic rts_out,
    output logic rts_route
);
    logic half_duplex_enable_r;   // Half-duplex mode
    logic [31:0] sc_ctrl_r;       // Smart card control
    logic [31:0] md_ctrl_r;       // Multidrop control
    logic [7:0] addr_match_r;     // Station address
    logic [7:0] dir_delay_r;      // Direction release delay
    logic [7:0] dp_addr_r;        // Data phase address
    logic dp_write_r;             // Data phase is a write
    logic [31:0] rd_nxt;
    logic [7:0] card_clock_divider;
    logic [7:0] extra_guard_time;
    logic [2:0] tx_retry_limit;
    logic card_clock_enable;
    logic protocol_select;
    logic nack_response_disable;
    logic direction_polarity_invert;
    logic auto_direction_enable;
    logic auto_address_detect_enable;
    logic multidrop_receiver_enable;
    logic multidrop_mode_enable;
    logic flush;                  // Clear buffer and transmit lock
    logic addr_byte;
    logic accept;
    logic fifo_push;
    logic [7:0] clk_cnt_r;        // Card clock divider count
    logic [2:0] retry_cnt_r;      // NACKs seen on this character
    logic aad_on_r;               // Matching address seen
    logic parity_err_r;           // Sticky parity error
    logic overrun_r;              // Character lost, buffer full
    ucm_pkg::ucm_dir_e dir_st_r;
    ucm_pkg::ucm_dir_e dir_nxt;
    logic [7:0] dly_cnt_r;

    assign card_clock_divider = sc_ctrl_r[ucm_pkg::SC_DIV_LSB +: 8];
    assign extra_guard_time = sc_ctrl_r[ucm_pkg::SC_GUARD_LSB +: 8];
    assign tx_retry_limit = sc_ctrl_r[ucm_pkg::SC_RETRY_LSB +: 3];
    assign card_clock_enable = sc_ctrl_r[ucm_pkg::SC_CLK_EN_BIT];
    assign protocol_select = sc_ctrl_r[ucm_pkg::SC_PROT_BIT];
    assign nack_response_disable = sc_ctrl_r[ucm_pkg::SC_NACK_DIS_BIT];
    assign direction_polarity_invert = md_ctrl_r[ucm_pkg::MD_INV_BIT];
    assign auto_direction_enable = md_ctrl_r[ucm_pkg::MD_ADC_BIT];
    assign auto_address_detect_enable = md_ctrl_r[ucm_pkg::MD_AAD_BIT];
    assign multidrop_receiver_enable = md_ctrl_r[ucm_pkg::MD_MULTIDROP_RECEIVER_ENABLE_BIT];
    assign multidrop_mode_enable = md_ctrl_r[ucm_pkg::MD_NMM_BIT];
    assign flush = dp_write_r && dp_addr_r == ucm_pkg::OFS_CONTROL
        && hwdata[ucm_pkg::CT_FLUSH_BIT];

    // Bus address phase capture; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_addr_r <= '0;
            dp_write_r <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_write_r <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                dp_addr_r <= haddr[7:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_nxt = '0;
        case (haddr[7:0])
            // [R5] single enable bit
            ucm_pkg::OFS_HALF_DUPLEX: rd_nxt[ucm_pkg::HD_EN_BIT] = half_duplex_enable_r;
            ucm_pkg::OFS_SMART_CARD: rd_nxt = sc_ctrl_r;
            ucm_pkg::OFS_MULTIDROP: rd_nxt = md_ctrl_r;
            ucm_pkg::OFS_ADDR_MATCH: rd_nxt[7:0] = addr_match_r;
            ucm_pkg::OFS_DIR_DELAY: rd_nxt[7:0] = dir_delay_r;
            ucm_pkg::OFS_STATUS: begin
                rd_nxt[ucm_pkg::ST_TX_ERROR_FLAG_BIT] = tx_error_flag;
                rd_nxt[ucm_pkg::ST_RXLOCK_BIT] = rx_lock;
                rd_nxt[ucm_pkg::ST_PARERR_BIT] = parity_err_r;
                rd_nxt[ucm_pkg::ST_AADON_BIT] = aad_on_r;
                rd_nxt[ucm_pkg::ST_DIR_BIT] = dir_st_r != ucm_pkg::DIR_IDLE;
                rd_nxt[ucm_pkg::ST_OVR_BIT] = overrun_r;
            end
            default: rd_nxt = '0;
        endcase
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // [R1] full duplex out of reset
            half_duplex_enable_r <= 1'b0;
            sc_ctrl_r <= '0;
            md_ctrl_r <= '0;
            addr_match_r <= '0;
            dir_delay_r <= '0;
        end else if (dp_write_r) begin
            case (dp_addr_r)
                ucm_pkg::OFS_HALF_DUPLEX: half_duplex_enable_r <= hwdata[ucm_pkg::HD_EN_BIT];
                ucm_pkg::OFS_SMART_CARD: sc_ctrl_r <= hwdata & ucm_pkg::SC_WR_MASK;
                ucm_pkg::OFS_MULTIDROP: md_ctrl_r <= hwdata & ucm_pkg::MD_WR_MASK;
                // [R17] address match value
                ucm_pkg::OFS_ADDR_MATCH: addr_match_r <= hwdata[7:0];
                ucm_pkg::OFS_DIR_DELAY: dir_delay_r <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Receiver lock while transmitting in half duplex
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_lock <= 1'b0;
        end else begin
            // [R2] lock after ongoing character
            rx_lock <= half_duplex_enable_r && tx_busy && (rx_lock || !rx_busy);
        end
    end

    // Card clock divider and pin routing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_cnt_r <= '0;
            card_clk <= 1'b0;
            card_clk_route <= 1'b0;
        end else begin
            // [R9] route pin to card clock
            card_clk_route <= card_clock_enable;
            if (!card_clock_enable) begin
                clk_cnt_r <= '0;
                card_clk <= 1'b0;
            // [R6] toggle every divider+1 cycles
            end else if (clk_cnt_r >= card_clock_divider) begin
                clk_cnt_r <= '0;
                card_clk <= !card_clk;
            end else begin
                clk_cnt_r <= clk_cnt_r + 8'h01;
            end
        end
    end

    // Guard time per character
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            guard_bits <= ucm_pkg::GUARD_NOMINAL;
        // [R10] T=1 keeps nominal guard
        end else if (protocol_select) begin
            guard_bits <= ucm_pkg::GUARD_NOMINAL;
        // [R7] extra guard under T=0
        end else if (extra_guard_time == ucm_pkg::GUARD_SINGLE_CODE) begin
            guard_bits <= ucm_pkg::GUARD_SINGLE;
        end else begin
            guard_bits <= ucm_pkg::GUARD_NOMINAL + {1'b0, extra_guard_time};
        end
    end

    // NACK retries and transmit error lock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            retry_cnt_r <= '0;
            tx_resend <= 1'b0;
            tx_error_flag <= 1'b0;
            tx_lock <= 1'b0;
        end else begin
            tx_resend <= 1'b0;
            if (flush) begin
                tx_lock <= 1'b0;
                tx_error_flag <= 1'b0;
                retry_cnt_r <= '0;
            end
            if (tx_char_ok) begin
                retry_cnt_r <= '0;
            end
            // [R8] retry, then error wins over clear
            if (card_nack && !protocol_select && !tx_lock) begin
                if (retry_cnt_r == tx_retry_limit) begin
                    tx_error_flag <= 1'b1;
                    tx_lock <= 1'b1;
                    retry_cnt_r <= '0;
                end else begin
                    retry_cnt_r <= retry_cnt_r + 3'h1;
                    tx_resend <= 1'b1;
                end
            end
        end
    end

    // NACK response on faulty card character
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nack_send <= 1'b0;
        end else begin
            // [R11] NACK only under T=0
            nack_send <= rx_char_faulty && !protocol_select && !nack_response_disable;
        end
    end

    // Receive acceptance: address detection and gating
    // [R16] parity error marks an address
    assign addr_byte = multidrop_mode_enable && rx_parity_err;
    always_comb begin
        accept = !rx_lock;
        if (multidrop_mode_enable) begin
            if (auto_address_detect_enable) begin
                // [R19] data only after a matching address
                accept = accept && !addr_byte && aad_on_r;
            end else begin
                // [R15] receiver enable gates data
                accept = accept && multidrop_receiver_enable;
            end
        end
    end
    assign fifo_push = rx_char_valid && accept;

    // Address flags and overrun
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aad_on_r <= 1'b0;
            parity_err_r <= 1'b0;
            address_event <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            address_event <= rx_char_valid && addr_byte;
            if (flush) begin
                parity_err_r <= 1'b0;
                overrun_r <= 1'b0;
            end
            if (rx_char_valid && addr_byte) begin
                parity_err_r <= 1'b1;
            end
            if (fifo_push && !rx_space) begin
                overrun_r <= 1'b1;
            end
            // [R14] detector off clears state
            if (!(multidrop_mode_enable && auto_address_detect_enable)) begin
                aad_on_r <= 1'b0;
            end else if (rx_char_valid && addr_byte) begin
                aad_on_r <= rx_char == addr_match_r;
            end
        end
    end

    // Receive buffer; when full, a character is dropped and overrun is set
    ucm_fifo #(
        .WIDTH(ucm_pkg::RX_FIFO_WIDTH),
        .DEPTH(ucm_pkg::RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(hclk),
        .rst_n(hresetn),
        .flush(flush),
        .in_valid(fifo_push),
        .in_ready(rx_space),
        .in_data(rx_char),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_data)
    );

    // Direction state: send, then hold for the delay
    always_comb begin
        dir_nxt = dir_st_r;
        case (dir_st_r)
            ucm_pkg::DIR_IDLE: if (tx_busy) dir_nxt = ucm_pkg::DIR_SEND;
            ucm_pkg::DIR_SEND: begin
                if (!tx_busy) begin
                    dir_nxt = (dir_delay_r == '0) ? ucm_pkg::DIR_IDLE : ucm_pkg::DIR_HOLD;
                end
            end
            ucm_pkg::DIR_HOLD: begin
                if (tx_busy) begin
                    dir_nxt = ucm_pkg::DIR_SEND;
                // [R18] release after delay bit times
                end else if (bit_tick && dly_cnt_r + 8'h01 >= dir_delay_r) begin
                    dir_nxt = ucm_pkg::DIR_IDLE;
                end
            end
            default: dir_nxt = ucm_pkg::DIR_IDLE;
        endcase
    end

    // Direction register, delay count and pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_st_r <= ucm_pkg::DIR_IDLE;
            dly_cnt_r <= '0;
            rts_out <= 1'b1;
            rts_route <= 1'b0;
        end else begin
            dir_st_r <= dir_nxt;
            if (dir_st_r != ucm_pkg::DIR_HOLD) begin
                dly_cnt_r <= '0;
            end else if (bit_tick) begin
                dly_cnt_r <= dly_cnt_r + 8'h01;
            end
            // [R12] polarity of direction level
            rts_out <= (dir_nxt != ucm_pkg::DIR_IDLE) == direction_polarity_invert;
            // [R13] route RTS pin for direction
            rts_route <= auto_direction_enable;
        end
    end

    // Checks
    // [R1] full duplex never locks
    full_duplex_a: // [R1]
        assert property (@(posedge hclk) disable iff (!hresetn)
            !half_duplex_enable_r |=> !rx_lock)
        else $error("receiver locked in full duplex");
    // [R2] lock follows idle receiver
    rx_lock_a: // [R2]
        assert property (@(posedge hclk) disable iff (!hresetn)
            half_duplex_enable_r && tx_busy && !rx_busy |=> rx_lock)
        else $error("receiver not locked");
    // [R5] upper bits read zero
    hd_read_a: // [R5]
        assert property (@(posedge hclk) disable iff (!hresetn)
            hsel && hready && htrans[1] && !hwrite
            && haddr[7:0] == ucm_pkg::OFS_HALF_DUPLEX |=> hrdata[31:1] == '0)
        else $error("half duplex reserved bits set");
    // [R6] toggle when count reaches divider
    card_clock_a: // [R6]
        assert property (@(posedge hclk) disable iff (!hresetn)
            card_clock_enable && clk_cnt_r == card_clock_divider
            ##1 card_clock_enable |-> card_clk != $past(card_clk))
        else $error("card clock missed toggle");
    // [R8] error after limit plus one NACKs
    tx_error_a: // [R8]
        assert property (@(posedge hclk) disable iff (!hresetn)
            card_nack && !protocol_select && !tx_lock
            && retry_cnt_r == tx_retry_limit |=> tx_error_flag && tx_lock && !tx_resend)
        else $error("transmit error not raised");
    // [R11] NACK on faulty character
    nack_resp_a: // [R11]
        assert property (@(posedge hclk) disable iff (!hresetn)
            rx_char_faulty && !protocol_select && !nack_response_disable |=> nack_send)
        else $error("NACK not sent");
    // [R12] busy drives active level
    rts_level_a: // [R12]
        assert property (@(posedge hclk) disable iff (!hresetn)
            tx_busy && !direction_polarity_invert |=> !rts_out)
        else $error("direction level wrong");
    // [R18] release when delay spent
    dir_release_a: // [R18]
        assert property (@(posedge hclk) disable iff (!hresetn)
            dir_st_r == ucm_pkg::DIR_HOLD && !tx_busy && bit_tick
            && dly_cnt_r + 8'h01 == dir_delay_r |=> dir_st_r == ucm_pkg::DIR_IDLE)
        else $error("direction not released");
    // [R15] disabled receiver stores nothing
    rx_gate_a: // [R15]
        assert property (@(posedge hclk) disable iff (!hresetn)
            multidrop_mode_enable && !auto_address_detect_enable
            && !multidrop_receiver_enable |-> !fifo_push)
        else $error("data accepted while disabled");
    // [R19] matching address opens reception
    aad_match_a: // [R19]
        assert property (@(posedge hclk) disable iff (!hresetn)
            multidrop_mode_enable && auto_address_detect_enable && rx_char_valid
            && addr_byte && rx_char == addr_match_r ##1
            multidrop_mode_enable && auto_address_detect_enable |-> aad_on_r)
        else $error("address match ignored");
    retry_c: cover property (@(posedge hclk) disable iff (!hresetn) tx_resend ##[1:50] tx_error_flag);
    aad_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(aad_on_r));
    hold_c: cover property (@(posedge hclk) disable iff (!hresetn)
        dir_st_r == ucm_pkg::DIR_HOLD ##1 dir_st_r == ucm_pkg::DIR_IDLE);
    full_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(rx_space));
endmodule

/* core/ucm_pkg.sv */
// Constants shared by the half-duplex, smart card and multidrop mode slice.
// Assumes a 32-bit AHB-Lite register bus and an 8-bit character path.
package ucm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_HALF_DUPLEX = 8'h34;
    localparam logic [7:0] OFS_SMART_CARD = 8'h38;
    localparam logic [7:0] OFS_MULTIDROP = 8'h3c;
    localparam logic [7:0] OFS_ADDR_MATCH = 8'h40;
    localparam logic [7:0] OFS_DIR_DELAY = 8'h44;
    localparam logic [7:0] OFS_STATUS = 8'h50;
    localparam logic [7:0] OFS_CONTROL = 8'h54;
    // Half-duplex field
    localparam int HD_EN_BIT = 0;
    // Smart card fields
    localparam int SC_DIV_LSB = 16;
    localparam int SC_GUARD_LSB = 8;
    localparam int SC_RETRY_LSB = 5;
    localparam int SC_CLK_EN_BIT = 3;
    localparam int SC_PROT_BIT = 2;
    localparam int SC_NACK_DIS_BIT = 1;
    localparam logic [31:0] SC_WR_MASK = 32'h00ff_ffee;
    // Multidrop fields
    localparam int MD_INV_BIT = 5;
    localparam int MD_ADC_BIT = 4;
    localparam int MD_AAD_BIT = 2;
    localparam int MD_MULTIDROP_RECEIVER_ENABLE_BIT = 1;
    localparam int MD_NMM_BIT = 0;
    localparam logic [31:0] MD_WR_MASK = 32'h0000_0037;
    // Status fields
    localparam int ST_TX_ERROR_FLAG_BIT = 0;
    localparam int ST_RXLOCK_BIT = 1;
    localparam int ST_PARERR_BIT = 2;
    localparam int ST_AADON_BIT = 3;
    localparam int ST_DIR_BIT = 4;
    localparam int ST_OVR_BIT = 5;
    // Control fields
    localparam int CT_FLUSH_BIT = 0;
    // Guard time figures, in bit times
    localparam logic [8:0] GUARD_NOMINAL = 9'h002;
    localparam logic [7:0] GUARD_SINGLE_CODE = 8'hff;
    localparam logic [8:0] GUARD_SINGLE = 9'h001;
    // Receive buffer shape
    localparam int RX_FIFO_WIDTH = 8;
    localparam int RX_FIFO_DEPTH = 8;
    // Direction control states
    typedef enum logic [1:0] {
        DIR_IDLE,
        DIR_SEND,
        DIR_HOLD
    } ucm_dir_e;
endpackage

/* verif/ucm_line_model.sv */
// Far-side model: a card or line that sends characters and NACKs.
// Assumes the bench raises send or nack_in for one cycle at a time.
`timescale 1ns/10ps
module ucm_line_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic send,
    input wire logic [7:0] byte_in,
    input wire logic par_in,
    input wire logic nack_in,
    output logic rx_char_valid,
    output logic [7:0] rx_char,
    output logic rx_parity_err,
    output logic card_nack
);
    // One strobe per character; idle data is inverted so stale bytes never pass
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_char_valid <= 1'b0;
            rx_char <= 8'h00;
            rx_parity_err <= 1'b0;
            card_nack <= 1'b0;
        end else begin
            rx_char_valid <= send;
            rx_char <= send ? byte_in : ~rx_char;
            rx_parity_err <= send & par_in;
            card_nack <= nack_in;
        end
    end
endmodule

/* verif/tb_ucm_top.sv */
// Self-checking bench for the mode-control slice, one task per scenario.
// Assumes a single AHB-Lite master and the line model as far side.
`timescale 1ns/10ps
module tb_ucm_top;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tx_busy = 0, send = 0, nack_in = 0;
    logic rx_out_ready = 0, faulty = 0, rx_char_valid, rx_parity_err, card_nack, hready, hready_o;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0] byte_in = 8'h00, rx_char, rx_out_data;
    logic rx_out_valid, rx_space, rx_lock, tx_lock, tx_resend, tx_error_flag, card_clk;
    logic card_clk_route, rts_out, rts_route, v, nack_send;
    logic [8:0] guard_bits;
    int bad_count = 0, checks = 0, cyc = 0;
    // Clock at 20 MHz; the one slave's ready is the bus ready
    always #25 hclk = ~hclk;
    assign hready = hready_o;
    ucm_line_model u_ucm_line_model (.clk(hclk), .rst_n(hresetn), .send(send),
        .byte_in(byte_in), .par_in(1'b0), .nack_in(nack_in), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rx_parity_err(rx_parity_err), .card_nack(card_nack));
    ucm_top u_ucm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready_o), .hresp(), .hrdata(hrdata), .bit_tick(1'b0), .tx_busy(tx_busy),
        .tx_char_ok(1'b0), .card_nack(card_nack), .rx_busy(1'b0),
        .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_parity_err(rx_parity_err),
        .rx_char_faulty(faulty), .rx_out_ready(rx_out_ready), .rx_out_valid(rx_out_valid),
        .rx_out_data(rx_out_data), .rx_space(rx_space), .rx_lock(rx_lock), .tx_lock(tx_lock),
        .tx_resend(tx_resend), .tx_error_flag(tx_error_flag), .nack_send(nack_send),
        .address_event(), .guard_bits(guard_bits), .card_clk(card_clk),
        .card_clk_route(card_clk_route), .rts_out(rts_out), .rts_route(rts_route));
    // Let n edges pass, then settle
    task tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    // Compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite word transfer, waiting on ready in both phases
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Cycle ceiling
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    task complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Fill to refusal with the sink stalled, then drain in order
    task t_fifo();
        for (int i = 0; i < 9; i++) begin
            send <= 1'b1;
            byte_in <= 8'h10 + 8'(i);
            tick(1);
        end
        send <= 1'b0;
        tick(2);
        chk(rx_space, 0);
        xfer(0, 8'h50, 0);
        chk(rd[5], 1);
        for (int i = 0; i < 8; i++) begin
            chk(rx_out_data, 8'h10 + 8'(i));
            rx_out_ready <= 1'b1;
            tick(1);
            rx_out_ready <= 1'b0;
            tick(1);
        end
        chk(rx_out_valid, 0);
        xfer(0, 8'h60, 0);
        chk(rd, 0);
        $display("test fifo done");
    endtask
    // Retry limit 1: first NACK resends, second sets error and lock
    task t_retry();
        // half duplex stays off in card mode
        xfer(1, 8'h38, 32'h00000020);
        faulty <= 1'b1;
        tick(1);
        faulty <= 1'b0;
        chk(nack_send, 1);
        nack_in <= 1'b1;
        tick(1);
        nack_in <= 1'b0;
        tick(1);
        chk(tx_resend, 1);
        nack_in <= 1'b1;
        tick(1);
        nack_in <= 1'b0;
        tick(1);
        chk({tx_error_flag, tx_lock}, 2'h3);
        xfer(1, 8'h54, 32'h1);
        tick(1);
        chk(tx_error_flag, 0);
        $display("test retry done");
    endtask
    // Guard figures, card clock and direction pin
    task t_modes();
        xfer(1, 8'h38, 32'h00000300);
        tick(1);
        chk(guard_bits, 9'h005);
        xfer(1, 8'h38, 32'h0001ff08);
        tick(1);
        chk({guard_bits, card_clk_route}, {9'h001, 1'b1});
        v = card_clk;
        tick(2);
        chk(card_clk, !v);
        xfer(1, 8'h3c, 32'h10);
        tx_busy <= 1'b1;
        tick(2);
        chk({rts_out, rts_route}, 2'h1);
        tx_busy <= 1'b0;
        tick(3);
        chk(rts_out, 1);
        // mode changed only while line idle
        xfer(1, 8'h34, 32'hffffffff);
        xfer(0, 8'h34, 0);
        chk(rd, 1);
        tx_busy <= 1'b1;
        tick(2);
        chk(rx_lock, 1);
        tx_busy <= 1'b0;
        $display("test modes done");
    endtask
    initial begin
        tick(5);
        hresetn <= 1'b1;
        tick(1);
        chk({rts_out, guard_bits}, {1'b1, 9'h002});
        xfer(0, 8'h3c, 0);
        chk(rd, 0);
        t_fifo();
        t_retry();
        t_modes();
        complete_run();
    end
endmodule
